/* File: metering_pkg.sv */
/*
 * shared constants of the line metering pulse scheduler: register map,
 * field positions, reset values, reply codes and timing counts.
 * assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package metering_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned MS_CYCLES     = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BURST_COUNT = 8'h00;
    localparam logic [7:0] OFS_INTERVAL    = 8'h04;
    localparam logic [7:0] OFS_COMMAND     = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0c;
    localparam logic [7:0] OFS_REPLY       = 8'h10;
    localparam logic [7:0] OFS_PULSE_CFG   = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CMD_BURST_BIT    = 0;
    localparam int unsigned CMD_PER_ON_BIT   = 1;
    localparam int unsigned CMD_PER_OFF_BIT  = 2;
    localparam int unsigned STAT_HOOK_BIT    = 0;
    localparam int unsigned STAT_BUSY_BIT    = 1;
    localparam int unsigned STAT_PER_BIT     = 2;
    localparam int unsigned STAT_PULSE_BIT   = 3;
    localparam int unsigned STAT_ERR_BIT     = 4;
    localparam int unsigned CFG_PAUSE_LSB    = 16;

    // ------------------------------------------------------------
    // reset and default values, reply codes and bus response codes
    // ------------------------------------------------------------
    localparam logic [31:0] DEF_COUNT        = 32'h0000_0001;
    localparam logic [31:0] DEF_INTERVAL_MS  = 32'h0000_03e8;
    localparam logic [15:0] RST_ON_MS        = 16'h0064;
    localparam logic [15:0] RST_PAUSE_MS     = 16'h0064;
    localparam logic [9:0]  REPLY_OK         = 10'h0c8;
    localparam logic [9:0]  REPLY_ON_HOOK    = 10'h192;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_DECERR      = 2'h3;
endpackage

/* File: shaper_if.sv */
/*
 * link between the scheduler and the pulse shaper.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface shaper_if;
    logic        start;
    logic        ms_tick;
    logic [15:0] on_ms;
    logic [15:0] pause_ms;
    logic        level;
    logic        ready;

    modport sched  (output start, ms_tick, on_ms, pause_ms,
                    input  level, ready);
    modport shaper (input  start, ms_tick, on_ms, pause_ms,
                    output level, ready);
endinterface
`default_nettype wire

/* File: metering_pulse_shaper.sv */
/*
 * shapes one metering pulse: on-period, then the least pause.
 * assumes start only while ready, and a one-cycle ms tick.
 */
`timescale 1ns/100ps
`default_nettype none
module metering_pulse_shaper (
    input  wire logic   core_clk,
    input  wire logic   rst,
    shaper_if.shaper    sh
);
    typedef enum logic [1:0] {SH_IDLE, SH_ON, SH_PAUSE} shape_state_e;

    shape_state_e state_q, state_d;
    logic [15:0]  cnt_q, cnt_d;
    logic         level_q, level_d;
    logic         ready_q, ready_d;

    assign sh.level = level_q;
    assign sh.ready = ready_q;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SH_IDLE: begin
                if (sh.start) begin
                    state_d = SH_ON;
                    // zero on-period still gives a one-tick pulse
                    cnt_d   = (sh.on_ms == 16'h0000) ? 16'h0001 : sh.on_ms;
                end
            end
            SH_ON: begin
                if (sh.ms_tick) begin
                    if (cnt_q <= 16'h0001) begin
                        state_d = (sh.pause_ms == 16'h0000) ? SH_IDLE : SH_PAUSE;
                        cnt_d   = sh.pause_ms;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
            end
            SH_PAUSE: begin
                if (sh.ms_tick) begin
                    if (cnt_q <= 16'h0001) begin
                        state_d = SH_IDLE;
                    end
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = SH_IDLE;
            end
        endcase
        level_d = (state_d == SH_ON);
        ready_d = (state_d == SH_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= SH_IDLE;
            cnt_q   <= 16'h0000;
            level_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            level_q <= level_d;
            ready_q <= ready_d;
        end
    end
endmodule
`default_nettype wire

/* File: line_metering_pulse_scheduler.sv */
/*
 * metering pulse scheduler for one analogue line with an AXI4-Lite
 * register slave. assumes a 125 MHz core clock, synchronous reset and an
 * asynchronous off-hook level from the line interface.
 */
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module line_metering_pulse_scheduler #(
    parameter int unsigned COUNT_W    = 16,
    parameter int unsigned INTERVAL_W = 20,
    parameter int unsigned MS_CYCLES  = metering_pkg::MS_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        off_hook,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             pulse_out,
    output logic             busy,
    output logic             periodic_active
);
    localparam int unsigned TICK_W = $clog2(MS_CYCLES);

    if (MS_CYCLES < 2 || COUNT_W < 1 || COUNT_W > 32 ||
        INTERVAL_W < 11 || INTERVAL_W > 32) begin
        $error("unsupported parameter values");
    end

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // hook synchroniser and millisecond tick
    // ------------------------------------------------------------
    logic              hook_s1_q, hook_s2_q, hook_s3_q, hook_q, hook_d;
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic              tick_q, tick_d;

    always_comb begin
        // a level change counts once stages two and three agree
        hook_d = (hook_s2_q == hook_s3_q) ? hook_s3_q : hook_q;
        // free-running divider
        if (tick_cnt_q == TICK_W'(MS_CYCLES - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end else begin
            tick_cnt_d = tick_cnt_q + TICK_W'(1);
            tick_d     = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hook_s1_q  <= 1'b0;
            hook_s2_q  <= 1'b0;
            hook_s3_q  <= 1'b0;
            hook_q     <= 1'b0;
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            hook_s1_q  <= off_hook;
            hook_s2_q  <= hook_s1_q;
            hook_s3_q  <= hook_s2_q;
            hook_q     <= hook_d;
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // ------------------------------------------------------------
    // bus slave handshakes
    // ------------------------------------------------------------
    logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0]  waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        bvalid_q, bvalid_d, arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wr_commit;
    logic [31:0] status_word;

    // scheduler state read back by the bus
    logic [COUNT_W-1:0]    count_reg_q, count_reg_d;
    logic [INTERVAL_W-1:0] ival_reg_q, ival_reg_d;
    logic [15:0]           on_ms_q, on_ms_d, pause_ms_q, pause_ms_d;
    logic [9:0]            reply_q, reply_d;
    logic                  err_q, err_d;
    logic                  pulse_q, busy_q, per_en_q;

    assign wr_commit = aw_full_q & w_full_q & ~bvalid_q;

    function automatic logic known_ofs(input logic [7:0] a);
        return a == metering_pkg::OFS_BURST_COUNT ||
               a == metering_pkg::OFS_INTERVAL    ||
               a == metering_pkg::OFS_COMMAND     ||
               a == metering_pkg::OFS_STATUS      ||
               a == metering_pkg::OFS_REPLY       ||
               a == metering_pkg::OFS_PULSE_CFG;
    endfunction

    always_comb begin
        status_word = '0;
        status_word[metering_pkg::STAT_HOOK_BIT]  = hook_q;
        status_word[metering_pkg::STAT_BUSY_BIT]  = busy_q;
        status_word[metering_pkg::STAT_PER_BIT]   = per_en_q;
        status_word[metering_pkg::STAT_PULSE_BIT] = pulse_q;
        status_word[metering_pkg::STAT_ERR_BIT]   = err_q;
    end

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        arready_d = arready_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            waddr_d   = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_commit) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = known_ofs(waddr_q) ? metering_pkg::RESP_OKAY
                                           : metering_pkg::RESP_DECERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = ~aw_full_d;
        wready_d  = ~w_full_d;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = metering_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                metering_pkg::OFS_BURST_COUNT: rdata_d = 32'(count_reg_q);
                metering_pkg::OFS_INTERVAL:    rdata_d = 32'(ival_reg_q);
                metering_pkg::OFS_COMMAND:     rdata_d = '0;
                metering_pkg::OFS_STATUS:      rdata_d = status_word;
                metering_pkg::OFS_REPLY:       rdata_d = 32'(reply_q);
                metering_pkg::OFS_PULSE_CFG:   rdata_d = {pause_ms_q, on_ms_q};
                default: begin
                    rdata_d = '0;
                    rresp_d = metering_pkg::RESP_DECERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= metering_pkg::RESP_OKAY;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= metering_pkg::RESP_OKAY;
            rdata_q   <= '0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // scheduler
    // ------------------------------------------------------------
    shaper_if sh ();

    logic [COUNT_W-1:0]    burst_left_q, burst_left_d;
    logic [INTERVAL_W-1:0] burst_ival_q, burst_ival_d;
    logic [INTERVAL_W-1:0] per_ival_q, per_ival_d;
    logic [INTERVAL_W-1:0] gap_q, gap_d;
    logic                  per_en_d, start_q, start_d, tail_q, tail_d;
    logic                  pulse_d, busy_d;
    logic [COUNT_W-1:0]    req_count;
    logic [INTERVAL_W-1:0] req_ival;
    logic                  can_fire, fire_burst, fire_per;
    logic                  cmd_wr;
    logic [31:0]           merged;

    assign sh.start    = start_q;
    assign sh.ms_tick  = tick_q;
    assign sh.on_ms    = on_ms_q;
    assign sh.pause_ms = pause_ms_q;

    metering_pulse_shaper u_shaper (
        .core_clk (core_clk),
        .rst      (rst),
        .sh       (sh)
    );

    always_comb begin
        count_reg_d  = count_reg_q;
        ival_reg_d   = ival_reg_q;
        on_ms_d      = on_ms_q;
        pause_ms_d   = pause_ms_q;
        reply_d      = reply_q;
        err_d        = err_q;
        burst_left_d = burst_left_q;
        burst_ival_d = burst_ival_q;
        per_ival_d   = per_ival_q;
        per_en_d     = per_en_q;
        gap_d        = gap_q;
        start_d      = 1'b0;
        tail_d       = tail_q;
        merged       = '0;
        cmd_wr       = 1'b0;
        // omitted (zero) parameters take their defaults
        req_count = (count_reg_q == '0) ? COUNT_W'(metering_pkg::DEF_COUNT)
                                        : count_reg_q;
        req_ival  = (ival_reg_q == '0)
                  ? INTERVAL_W'(metering_pkg::DEF_INTERVAL_MS) : ival_reg_q;

        // the shaper's ready lags start by one cycle, hence !start_q
        can_fire   = sh.ready && !start_q && (gap_q == '0);
        // burst pulses take priority over the periodic train
        fire_burst = can_fire && (burst_left_q != '0);
        fire_per   = can_fire && (burst_left_q == '0) && per_en_q;
        if (fire_burst) begin
            start_d      = 1'b1;
            burst_left_d = burst_left_q - COUNT_W'(1);
            gap_d        = burst_ival_q;
            tail_d       = (burst_left_q == COUNT_W'(1));
        end else if (fire_per) begin
            start_d = 1'b1;
            gap_d   = per_ival_q;
        end else if (tick_q && gap_q != '0) begin
            gap_d = gap_q - INTERVAL_W'(1);
        end
        if (tail_q && sh.ready && !start_q) begin
            tail_d = 1'b0;
        end

        if (wr_commit) begin
            merged = strb_merge('0, wdata_q, wstrb_q);
            case (waddr_q)
                metering_pkg::OFS_BURST_COUNT: begin
                    count_reg_d = COUNT_W'(strb_merge(32'(count_reg_q),
                                                      wdata_q, wstrb_q));
                end
                metering_pkg::OFS_INTERVAL: begin
                    ival_reg_d = INTERVAL_W'(strb_merge(32'(ival_reg_q),
                                                        wdata_q, wstrb_q));
                end
                metering_pkg::OFS_COMMAND: begin
                    cmd_wr = wstrb_q[0];
                end
                metering_pkg::OFS_STATUS: begin
                    if (merged[metering_pkg::STAT_ERR_BIT]) begin
                        err_d = 1'b0;
                    end
                end
                metering_pkg::OFS_PULSE_CFG: begin
                    // provisioned shape only changes between calls
                    if (!hook_q) begin
                        {pause_ms_d, on_ms_d} = strb_merge({pause_ms_q, on_ms_q},
                                                           wdata_q, wstrb_q);
                    end
                end
                default: begin
                end
            endcase
        end

        // going on-hook stops the periodic train only
        if (!hook_q) begin
            per_en_d = 1'b0;
        end

        if (cmd_wr) begin
            reply_d = metering_pkg::REPLY_OK;
            if (wdata_q[metering_pkg::CMD_BURST_BIT]) begin
                if (!hook_q) begin
                    reply_d = metering_pkg::REPLY_ON_HOOK;
                end else begin
                    // a second burst adds to what is still owed
                    if (burst_left_d == '0) begin
                        gap_d = '0;
                    end
                    burst_left_d = burst_left_d + req_count;
                    burst_ival_d = req_ival;
                end
            end
            if (wdata_q[metering_pkg::CMD_PER_ON_BIT]) begin
                if (!hook_q) begin
                    reply_d = metering_pkg::REPLY_ON_HOOK;
                end else begin
                    per_en_d   = 1'b1;
                    per_ival_d = req_ival;
                    if (burst_left_d == '0) begin
                        gap_d = '0;
                    end
                end
            end
            if (wdata_q[metering_pkg::CMD_PER_OFF_BIT]) begin
                per_en_d = 1'b0;
            end
        end
        // a new error outranks a clear in the same cycle
        if (cmd_wr && reply_d == metering_pkg::REPLY_ON_HOOK) begin
            err_d = 1'b1;
        end
        pulse_d = sh.level;
        busy_d  = (burst_left_d != '0) || tail_d;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_reg_q  <= '0;
            ival_reg_q   <= '0;
            on_ms_q      <= metering_pkg::RST_ON_MS;
            pause_ms_q   <= metering_pkg::RST_PAUSE_MS;
            reply_q      <= metering_pkg::REPLY_OK;
            err_q        <= 1'b0;
            burst_left_q <= '0;
            burst_ival_q <= INTERVAL_W'(metering_pkg::DEF_INTERVAL_MS);
            per_ival_q   <= INTERVAL_W'(metering_pkg::DEF_INTERVAL_MS);
            per_en_q     <= 1'b0;
            gap_q        <= '0;
            start_q      <= 1'b0;
            tail_q       <= 1'b0;
            pulse_q      <= 1'b0;
            busy_q       <= 1'b0;
        end else begin
            count_reg_q  <= count_reg_d;
            ival_reg_q   <= ival_reg_d;
            on_ms_q      <= on_ms_d;
            pause_ms_q   <= pause_ms_d;
            reply_q      <= reply_d;
            err_q        <= err_d;
            burst_left_q <= burst_left_d;
            burst_ival_q <= burst_ival_d;
            per_ival_q   <= per_ival_d;
            per_en_q     <= per_en_d;
            gap_q        <= gap_d;
            start_q      <= start_d;
            tail_q       <= tail_d;
            pulse_q      <= pulse_d;
            busy_q       <= busy_d;
        end
    end

    assign s_axi_awready   = awready_q;
    assign s_axi_wready    = wready_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = arready_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rresp     = rresp_q;
    assign s_axi_rdata     = rdata_q;
    assign pulse_out       = pulse_q;
    assign busy            = busy_q;
    assign periodic_active = per_en_q;
endmodule
`default_nettype wire

/* File: subscriber_line.sv */
/* subscriber hook switch model: lift means off hook.
   assumes the bench moves lift just after a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module subscriber_line (
    input  wire logic lift,
    output logic      off_hook
);
    assign off_hook = lift;
endmodule
`default_nettype wire

/* File: line_metering_pulse_scheduler_assertions.sv */
/* port assertions of the metering scheduler.
   assumes 8-cycle ms ticks and 1 ms pulse on and pause. */
`timescale 1ns/100ps
`default_nettype none
module line_metering_pulse_scheduler_assertions (
    input wire logic        core_clk, rst, off_hook, busy, pulse_out,
    input wire logic        periodic_active, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid
        ##1 !s_axi_bvalid)
        else $error("write answer wrong");
    write_hold_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write ready not held off");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer wrong");
    decerr_read_a: assert property (rd_take and (s_axi_araddr[7:2] > 6'h05)
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    burst_start_a:
        assert property ($rose(busy) |-> ##[1:40] $rose(pulse_out))
        else $error("burst gave no pulse");
    busy_end_a:
        assert property ($fell(busy) |-> !pulse_out)
        else $error("busy fell during a pulse");
    hook_stop_a:
        assert property (!off_hook [*8] |=> !periodic_active)
        else $error("periodic kept on hook");
    periodic_first_a:
        assert property ($rose(periodic_active) && !busy
            |-> ##[1:40] $rose(pulse_out))
        else $error("periodic first pulse late");
    pulse_cause_a:
        assert property ($rose(pulse_out) |-> busy
            || $past(periodic_active, 3) || $past(periodic_active, 4))
        else $error("pulse with no request");
endmodule
bind line_metering_pulse_scheduler
    line_metering_pulse_scheduler_assertions chk (.*);
`default_nettype wire

/* File: test_line_metering_pulse_scheduler.sv */
/* bench of the metering scheduler: burst table, hook replies, periodic.
   assumes ms ticks shortened to 8 clocks. */
`timescale 1ns/100ps
`default_nettype none
module test_line_metering_pulse_scheduler;
    logic core_clk = 0, rst = 1, lift = 0, off_hook, p_q = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pulse_out, busy, periodic_active;
    int err_total = 0, total_checks = 0, pulses = 0, cyc = 0, last = 0, gap;
    int rows [2][2] = '{'{0, 1}, '{3, 3}};
    int hook_rows [3][2] = '{'{1, 'h192}, '{2, 'h192}, '{4, 'hc8}};
    always #4 core_clk = ~core_clk;
    subscriber_line line (.lift(lift), .off_hook(off_hook));
    line_metering_pulse_scheduler #(.MS_CYCLES(8)) uut (.*);
    always @(posedge core_clk) begin
        cyc++;
        p_q <= pulse_out;
        if (pulse_out && !p_q) begin
            pulses++;
            gap = cyc - last;
            last = cyc;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        br = s_axi_bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge core_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 0;
        repeat (8) @(posedge core_clk);
        // shape is only taken while on hook
        wr(8'h14, 32'h0001_0001);
        lift <= 1;
        repeat (8) @(posedge core_clk);
        wr(8'h14, 32'h0005_0005);
        rdr(8'h14);
        chk(rd, 32'h0001_0001);
        wr(8'h04, 32'h3);
        foreach (rows[i]) begin
            pulses = 0;
            wr(8'h00, rows[i][0]);
            wr(8'h08, 32'h1);
            idle(4);
            chk(pulses, rows[i][1]);
        end
        chk(gap > 16 && gap < 32, 1);
        pulses = 0;
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h1);
        lift <= 0;
        idle(4);
        chk(pulses, 4);
        pulses = 0;
        foreach (hook_rows[i]) begin
            wr(8'h08, hook_rows[i][0]);
            rdr(8'h10);
            chk(rd, hook_rows[i][1]);
        end
        rdr(8'h20);
        chk(rd, 0);
        wr(8'h20, 32'h0);
        chk(br, 2'h3);
        rdr(8'h0c);
        chk(rd, 32'h10);
        wr(8'h0c, 32'h10);
        rdr(8'h0c);
        chk(rd, 32'h0);
        idle(40);
        chk({pulses > 0, periodic_active}, 0);
        lift <= 1;
        idle(8);
        wr(8'h08, 32'h2);
        idle(100);
        chk({pulses > 2, periodic_active}, 3);
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h1);
        idle(4);
        pulses = 0;
        idle(60);
        chk({pulses > 0, periodic_active}, 3);
        lift <= 0;
        idle(40);
        pulses = 0;
        idle(60);
        chk({pulses > 0, periodic_active}, 0);
        rst <= 1;
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rdr(8'h14);
        chk(rd, {metering_pkg::RST_PAUSE_MS,
                 metering_pkg::RST_ON_MS});
        complete_run();
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
